/* File: common/dmach_pkg.sv */
// Purpose: Shared constants and types of the DMA channel block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Offsets are byte addresses within the block
package dmach_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTL     = 8'h00;
    localparam logic [7:0] OFS_SA_LO   = 8'h04;
    localparam logic [7:0] OFS_SA_HI   = 8'h08;
    localparam logic [7:0] OFS_SA_FULL = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h14;

    // Channel control bit positions
    localparam int CTL_REQ   = 0;
    localparam int CTL_ABORT = 1;
    localparam int CTL_IE    = 2;
    localparam int CTL_IFG   = 3;
    localparam int CTL_EN    = 4;

    // Interrupt status bit positions
    localparam int STS_DONE  = 0;
    localparam int STS_ABORT = 1;
    localparam int STS_W     = 2;

    // Source address field widths
    localparam int SA_LO_W = 16;
    localparam int SA_HI_W = 4;
    localparam int SA_W    = SA_LO_W + SA_HI_W;

    // Reset values
    localparam logic [15:0]      RST_SA_LO = 16'h0000;
    localparam logic [3:0]       RST_SA_HI = 4'h0;
    localparam logic [STS_W-1:0] RST_STS   = 2'b00;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Read request towards system memory
    typedef struct packed {
        logic            valid;
        logic [SA_W-1:0] addr;
    } dmach_mem_req_t;

    // Channel sequencer states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_READ = 1'b1
    } dmach_state_t;

endpackage : dmach_pkg

/* File: hw/dmach_sync.sv */
// Purpose: Two-flop synchroniser for one asynchronous level
// Assumes: Destination clock is aclk
// Notes:   First stage feeds only the second stage
module dmach_sync (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_reg;

    // Two stages in series
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : dmach_sync

/* File: hw/dmach_channel.sv */
// Purpose: One DMA channel: control bits, source address, read sequencer
// Assumes: AXI4-Lite slave on aclk; trigger and nmi pins are asynchronous
// Notes:   Memory read port is a valid/ready request on aclk

// Functional notes
// - Abort bit records nmi-interrupted transfer
// - Writing one to request bit starts transfer
// - Request bit clears itself when taken
// - Source address is first read address
// - Working address separate; register stays unchanged
// - Narrow range: word write clears upper word
// - Narrow range: upper word reads zero
// - Wide range: upper bits 15-4 read zero
// - Wide range: word write clears upper word
// - Wide range: upper word word-reads return zero
module dmach_channel
    import dmach_pkg::*;
#(
    parameter bit WIDE_RANGE = 1'b1,
    parameter int LEN_W      = 16,
    parameter int STEP       = 2
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write channels
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Trigger and transfer shape
    input  wire logic                  trigger_pin,
    input  wire logic                  nmi_pin,
    input  wire logic                  block_mode,
    input  wire logic [LEN_W-1:0]      block_len,
    // Memory read request
    output dmach_pkg::dmach_mem_req_t  mem_req,
    input  wire logic                  mem_ready,
    // Status and interrupt
    output logic                       busy,
    output logic                       irq
);

    // Write channel holding state
    logic                  aw_held_reg;
    logic [7:0]            awaddr_reg;
    logic                  w_held_reg;
    logic [31:0]           wdata_reg;
    logic [3:0]            wstrb_reg;
    logic                  bvalid_reg;
    logic [1:0]            bresp_reg;
    logic                  do_write;
    // Read channel state
    logic                  rvalid_reg;
    logic [31:0]           rdata_reg;
    logic [1:0]            rresp_reg;
    logic [31:0]           rd_mux;
    logic                  rd_hit;
    logic                  wr_hit;
    // Control bits
    logic                  en_reg;
    logic                  ifg_reg;
    logic                  ie_reg;
    logic                  abort_reg;
    logic                  req_reg;
    // Source address
    logic [SA_LO_W-1:0]    sa_lo_reg;
    logic [SA_HI_W-1:0]    sa_hi_reg;
    // Interrupt status and mask
    logic [STS_W-1:0]      sts_reg;
    logic [STS_W-1:0]      msk_reg;
    // Sequencer
    dmach_state_t          state_reg;
    logic [SA_W-1:0]       work_addr_reg;
    logic [LEN_W-1:0]      remain_reg;
    logic                  trig_sync;
    logic                  trig_prev_reg;
    logic                  trig_edge;
    logic                  nmi_sync;
    logic                  start;
    logic                  done_evt;
    logic                  abort_evt;
    logic                  wr_ctl;
    logic                  wr_sa_lo;
    logic                  wr_sa_hi;
    logic                  wr_sa_full;
    logic                  wr_sts;
    logic                  wr_msk;

    // Pin synchronisers
    dmach_sync u_sync_trig (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (trigger_pin),
        .sync_out (trig_sync)
    );

    dmach_sync u_sync_nmi (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (nmi_pin),
        .sync_out (nmi_sync)
    );

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : merge16

    // Bus handshakes
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    // Write decode
    always_comb begin
        wr_ctl     = do_write && (awaddr_reg == OFS_CTL);
        wr_sa_lo   = do_write && (awaddr_reg == OFS_SA_LO);
        wr_sa_hi   = do_write && (awaddr_reg == OFS_SA_HI);
        wr_sa_full = do_write && (awaddr_reg == OFS_SA_FULL);
        wr_sts     = do_write && (awaddr_reg == OFS_IRQ_STS);
        wr_msk     = do_write && (awaddr_reg == OFS_IRQ_MSK);
        wr_hit     = wr_ctl || wr_sa_lo || wr_sa_hi || wr_sa_full || wr_sts || wr_msk;
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Enable and interrupt enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_reg <= 1'b0;
            ie_reg <= 1'b0;
        end else if (wr_ctl && wstrb_reg[0]) begin
            en_reg <= wdata_reg[CTL_EN];
            ie_reg <= wdata_reg[CTL_IE];
        end
    end

    // Completion flag, set wins over software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ifg_reg <= 1'b0;
        end else if (done_evt) begin
            ifg_reg <= 1'b1;
        end else if (wr_ctl && wstrb_reg[0]) begin
            ifg_reg <= wdata_reg[CTL_IFG];
        end
    end

    // Abort flag, set wins over software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            abort_reg <= 1'b0;
        end else if (abort_evt) begin
            abort_reg <= 1'b1;
        end else if (wr_ctl && wstrb_reg[0]) begin
            abort_reg <= wdata_reg[CTL_ABORT];
        end
    end

    // Software start request, self-clearing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_reg <= 1'b0;
        end else if (wr_ctl && wstrb_reg[0] && wdata_reg[CTL_REQ]) begin
            req_reg <= 1'b1;
        end else if (start || !en_reg || ((state_reg == ST_IDLE) && block_mode && (block_len == '0))) begin
            req_reg <= 1'b0;
        end
    end

    // Source address low and upper words; low word write clears upper word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sa_lo_reg <= RST_SA_LO;
            sa_hi_reg <= RST_SA_HI;
        end else if (wr_sa_lo) begin
            sa_lo_reg <= merge16(sa_lo_reg, wdata_reg, wstrb_reg);
            sa_hi_reg <= RST_SA_HI;
        end else if (wr_sa_full) begin
            sa_lo_reg <= merge16(sa_lo_reg, wdata_reg, wstrb_reg);
            if (WIDE_RANGE && wstrb_reg[2]) begin
                sa_hi_reg <= wdata_reg[SA_LO_W +: SA_HI_W];
            end
        end else if (wr_sa_hi && WIDE_RANGE && wstrb_reg[0]) begin
            sa_hi_reg <= wdata_reg[SA_HI_W-1:0];
        end
    end

    // Interrupt status (write one to clear, set wins) and mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sts_reg <= RST_STS;
            msk_reg <= RST_STS;
        end else begin
            sts_reg[STS_DONE]  <= done_evt ||
                (sts_reg[STS_DONE] && !(wr_sts && wstrb_reg[0] && wdata_reg[STS_DONE]));
            sts_reg[STS_ABORT] <= abort_evt ||
                (sts_reg[STS_ABORT] && !(wr_sts && wstrb_reg[0] && wdata_reg[STS_ABORT]));
            if (wr_msk && wstrb_reg[0]) begin
                msk_reg <= wdata_reg[STS_W-1:0];
            end
        end
    end

    // Read data select
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFS_CTL: begin
                rd_mux[CTL_EN]    = en_reg;
                rd_mux[CTL_IFG]   = ifg_reg;
                rd_mux[CTL_IE]    = ie_reg;
                rd_mux[CTL_ABORT] = abort_reg;
                rd_mux[CTL_REQ]   = req_reg;
            end
            OFS_SA_LO: begin
                rd_mux[SA_LO_W-1:0] = sa_lo_reg;
            end
            OFS_SA_HI: begin
                rd_mux = 32'h0000_0000;
            end
            OFS_SA_FULL: begin
                rd_mux[SA_LO_W-1:0]       = sa_lo_reg;
                rd_mux[SA_LO_W +: SA_HI_W] = WIDE_RANGE ? sa_hi_reg : RST_SA_HI;
            end
            OFS_IRQ_STS: begin
                rd_mux[STS_W-1:0] = sts_reg;
            end
            OFS_IRQ_MSK: begin
                rd_mux[STS_W-1:0] = msk_reg;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Trigger rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_sync;
        end
    end

    assign trig_edge = trig_sync && !trig_prev_reg;

    // Start only when enabled, idle and length nonzero
    assign start = en_reg && (state_reg == ST_IDLE) && (req_reg || trig_edge) &&
                   !(block_mode && (block_len == '0));

    // Sequencer events
    assign done_evt  = (state_reg == ST_READ) && !nmi_sync && en_reg && mem_ready &&
                       (remain_reg == LEN_W'(1));
    assign abort_evt = (state_reg == ST_READ) && nmi_sync;

    // Transfer sequencer with private working address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg     <= ST_IDLE;
            work_addr_reg <= '0;
            remain_reg    <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg     <= ST_READ;
                        work_addr_reg <= {sa_hi_reg, sa_lo_reg};
                        remain_reg    <= block_mode ? block_len : LEN_W'(1);
                    end
                end
                ST_READ: begin
                    if (nmi_sync || !en_reg) begin
                        state_reg <= ST_IDLE;
                    end else if (mem_ready) begin
                        work_addr_reg <= work_addr_reg + SA_W'(STEP);
                        remain_reg    <= remain_reg - LEN_W'(1);
                        if (remain_reg == LEN_W'(1)) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Memory request from flops
    assign mem_req.valid = (state_reg == ST_READ);
    assign mem_req.addr  = work_addr_reg;
    assign busy          = (state_reg == ST_READ);

    // Interrupt output
    assign irq = (ifg_reg && ie_reg) || |(sts_reg & msk_reg);

endmodule : dmach_channel

/* File: verif/dmach_asserts.sv */
// Purpose: Concurrent checks on the DMA channel ports
// Assumes: Single aclk domain, synchronous active-low reset
// Notes:   Attached to every dmach_channel by bind
module dmach_asserts
    import dmach_pkg::*;
#(
    parameter int STEP = 2
) (
    // Clock and reset
    input wire logic                      aclk,
    input wire logic                      aresetn,
    // Register bus handshakes
    input wire logic                      s_axi_awvalid,
    input wire logic                      s_axi_awready,
    input wire logic                      s_axi_wvalid,
    input wire logic                      s_axi_wready,
    input wire logic [1:0]                s_axi_bresp,
    input wire logic                      s_axi_bvalid,
    input wire logic                      s_axi_bready,
    input wire logic                      s_axi_arvalid,
    input wire logic                      s_axi_arready,
    input wire logic [31:0]               s_axi_rdata,
    input wire logic                      s_axi_rvalid,
    input wire logic                      s_axi_rready,
    // Abort pin, memory port, status
    input wire logic                      nmi_pin,
    input wire dmach_pkg::dmach_mem_req_t mem_req,
    input wire logic                      mem_ready,
    input wire logic                      busy,
    input wire logic                      irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // One clock domain for every check
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Memory request and bus answers
    a_req_hold_addr: assert property (mem_req.valid && !mem_ready && !$past(nmi_pin, 2)
        |=> mem_req.valid && $stable(mem_req.addr))
        else $error("read request changed before accept");
    a_addr_step: assert property (mem_req.valid && mem_ready ##1 mem_req.valid
        |-> mem_req.addr == SA_W'($past(mem_req.addr) + STEP))
        else $error("working address did not advance by one step");
    a_valid_busy: assert property (mem_req.valid |-> busy)
        else $error("read request without busy");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_nmi_stop: assert property ($rose(nmi_pin) ##0 nmi_pin [*5] |-> !busy && !mem_req.valid)
        else $error("transfer kept running under abort");

    // Main scenarios reached
    c_read_accept: cover property (mem_req.valid && mem_ready);
    c_irq_rise:    cover property ($rose(irq));
    c_slverr:      cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : dmach_asserts

bind dmach_channel dmach_asserts #(.STEP(STEP)) u_chk (.*);

/* File: verif/dmach_mem_model.sv */
// Purpose: System memory seen by the channel read port
// Assumes: Request held until accepted
// Notes:   Slow mode accepts every other cycle
module dmach_mem_model
    import dmach_pkg::*;
(
    // Clock and reset
    input wire logic                      aclk,
    input wire logic                      aresetn,
    // Read port
    input wire dmach_pkg::dmach_mem_req_t mem_req,
    input wire logic                      slow,
    output logic                          mem_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    // Ready registered from the previous cycle's request, stalling in slow mode
    always_ff @(posedge aclk) begin
        if (!aresetn || !mem_req.valid) begin
            mem_ready <= 1'b0;
        end else if (slow) begin
            mem_ready <= ~mem_ready;
        end else begin
            mem_ready <= 1'b1;
        end
    end
endmodule : dmach_mem_model

/* File: verif/tb.sv */
// Purpose: Self-checking bench of a DMA channel and its narrow-range twin
// Assumes: 40 MHz aclk, AXI4-Lite master tasks
// Notes:   Accepted read addresses are logged at the falling edge
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dmach_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, busy, irq, mem_ready;
    logic trigger_pin = 0, nmi_pin = 0, block_mode = 0, slow = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rdata_n;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp;
    logic [15:0] block_len = 0;
    dmach_mem_req_t mem_req;
    logic [SA_W-1:0] addr_q[$];
    int err_total = 0, total_checks = 0, cyc = 0;

    always #12.5 aclk = ~aclk;

    dmach_channel dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trigger_pin(trigger_pin),
        .nmi_pin(nmi_pin), .block_mode(block_mode), .block_len(block_len), .mem_req(mem_req),
        .mem_ready(mem_ready), .busy(busy), .irq(irq));
    dmach_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req), .slow(slow),
        .mem_ready(mem_ready));
    // Narrow-range twin in lockstep; only its read data is judged
    dmach_channel #(.WIDE_RANGE(1'b0)) dut_n (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(rdata_n), .s_axi_rresp(), .s_axi_rvalid(),
        .s_axi_rready(rready), .trigger_pin(trigger_pin), .nmi_pin(nmi_pin), .block_mode(block_mode),
        .block_len(block_len), .mem_req(), .mem_ready(mem_ready), .busy(), .irq());

    // Log accepted reads; falling edge shows the next rising edge's values
    always @(negedge aclk) if (aresetn && mem_req.valid && mem_ready) addr_q.push_back(mem_req.addr);

    // Hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Write with both halves offered together, response compared
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic ha, hw, hb;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= s; wvalid <= 1; bready <= 1;
        hb = 0;
        while (!hb) begin
            @(negedge aclk);
            ha = awvalid && awready; hw = wvalid && wready; hb = bvalid && bready; r = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
            if (hb) bready <= 0;
        end
        chk(32'(r), 32'(er));
    endtask : axi_wr

    // Read and compare data and response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ha, hr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        hr = 0;
        while (!hr) begin
            @(negedge aclk);
            ha = arvalid && arready; hr = rvalid && rready; d = rdata; r = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 0;
            if (hr) rready <= 0;
        end
        chk(d, exp);
        chk(32'(r), 32'(er));
    endtask : rd_chk

    task automatic wait_reads(input int n);
        for (int k = 0; k < 400 && addr_q.size() < n; k++) @(posedge aclk);
        repeat (6) @(posedge aclk);
        @(negedge aclk);
    endtask : wait_reads

    task automatic t_regs();
        rd_chk(OFS_CTL, 32'h0000_0000, RESP_OKAY);
        rd_chk(OFS_SA_FULL, 32'h0000_0000, RESP_OKAY);
        rd_chk(OFS_IRQ_STS, 32'h0000_0000, RESP_OKAY);
        rd_chk(8'h18, 32'h0000_0000, RESP_SLVERR);
        axi_wr(8'h18, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        $display("test regs done");
    endtask : t_regs

    task automatic t_addr();
        axi_wr(OFS_SA_FULL, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        rd_chk(OFS_SA_FULL, 32'h000F_FFFF, RESP_OKAY);
        chk(rdata_n, 32'h0000_FFFF);
        rd_chk(OFS_SA_HI, 32'h0000_0000, RESP_OKAY);
        chk(rdata_n, 32'h0000_0000);
        axi_wr(OFS_SA_LO, 32'h0000_ABCD, 4'h3, RESP_OKAY);
        rd_chk(OFS_SA_FULL, 32'h0000_ABCD, RESP_OKAY);
        chk(rdata_n, 32'h0000_ABCD);
        $display("test address done");
    endtask : t_addr

    task automatic t_single();
        axi_wr(OFS_SA_FULL, 32'h0003_0100, 4'h7, RESP_OKAY);
        addr_q.delete();
        axi_wr(OFS_CTL, 32'h0000_0015, 4'h1, RESP_OKAY);
        wait_reads(1);
        chk(32'(addr_q.size()), 32'h0000_0001);
        chk(32'(addr_q[0]), 32'h0003_0100);
        chk(32'(busy), 32'h0000_0000);
        chk(32'(irq), 32'h0000_0001);
        rd_chk(OFS_CTL, 32'h0000_001C, RESP_OKAY);
        axi_wr(OFS_CTL, 32'h0000_0014, 4'h1, RESP_OKAY);
        @(negedge aclk);
        chk(32'(irq), 32'h0000_0000);
        wait_reads(2);
        chk(32'(addr_q.size()), 32'h0000_0001);
        $display("test single done");
    endtask : t_single

    task automatic t_block();
        @(posedge aclk);
        block_len <= 16'h0003; block_mode <= 1; slow <= 1;
        addr_q.delete();
        axi_wr(OFS_CTL, 32'h0000_0011, 4'h1, RESP_OKAY);
        wait_reads(3);
        chk(32'(addr_q.size()), 32'h0000_0003);
        for (int i = 0; i < 3; i++) chk(32'(addr_q[i]), 32'h0003_0100 + 32'(i * 2));
        rd_chk(OFS_SA_FULL, 32'h0003_0100, RESP_OKAY);
        rd_chk(OFS_CTL, 32'h0000_0018, RESP_OKAY);
        block_len <= 16'h0000;
        axi_wr(OFS_CTL, 32'h0000_0011, 4'h1, RESP_OKAY);
        wait_reads(4);
        chk(32'(addr_q.size()), 32'h0000_0003);
        rd_chk(OFS_CTL, 32'h0000_0010, RESP_OKAY);
        $display("test block done");
    endtask : t_block

    task automatic pulse_trigger();
        @(posedge aclk) trigger_pin <= 1;
        repeat (4) @(posedge aclk);
        trigger_pin <= 0;
        repeat (6) @(posedge aclk);
    endtask : pulse_trigger

    task automatic t_disabled();
        block_mode <= 0; slow <= 0;
        addr_q.delete();
        axi_wr(OFS_CTL, 32'h0000_0001, 4'h1, RESP_OKAY);
        pulse_trigger();
        chk(32'(addr_q.size()), 32'h0000_0000);
        rd_chk(OFS_CTL, 32'h0000_0000, RESP_OKAY);
        axi_wr(OFS_CTL, 32'h0000_0010, 4'h1, RESP_OKAY);
        pulse_trigger();
        wait_reads(1);
        chk(32'(addr_q.size()), 32'h0000_0001);
        $display("test disabled done");
    endtask : t_disabled

    task automatic t_nmi();
        axi_wr(OFS_IRQ_STS, 32'h0000_0003, 4'h1, RESP_OKAY);
        block_len <= 16'h0008; block_mode <= 1; slow <= 1;
        addr_q.delete();
        axi_wr(OFS_CTL, 32'h0000_0011, 4'h1, RESP_OKAY);
        for (int k = 0; k < 100 && addr_q.size() < 1; k++) @(posedge aclk);
        nmi_pin <= 1;
        repeat (8) @(posedge aclk);
        nmi_pin <= 0;
        @(negedge aclk);
        chk(32'(busy), 32'h0000_0000);
        rd_chk(OFS_CTL, 32'h0000_0012, RESP_OKAY);
        rd_chk(OFS_IRQ_STS, 32'h0000_0002, RESP_OKAY);
        chk(32'(irq), 32'h0000_0000);
        axi_wr(OFS_IRQ_MSK, 32'h0000_0002, 4'h1, RESP_OKAY);
        @(negedge aclk);
        chk(32'(irq), 32'h0000_0001);
        axi_wr(OFS_IRQ_STS, 32'h0000_0002, 4'h1, RESP_OKAY);
        @(negedge aclk);
        chk(32'(irq), 32'h0000_0000);
        $display("test abort done");
    endtask : t_nmi

    // Reset, then the scenarios in order
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_regs();
        t_addr();
        t_single();
        t_block();
        t_disabled();
        t_nmi();
        report_and_stop();
    end
endmodule : tb
